// file: include/tcd_pkg.sv
// constants, types and reset values shared by both ends of the dma link
// assumes one clock and one synchronous active-high reset for all files
//
// Contract
// - two independent channels selected by identifier
// - controller supplies descriptor; channel runs transfer
// - descriptor holds 16-bit OR of flags
// - chain set: load next descriptor at end
// - source inner stride is 16 bits
// - destination inner stride independent, 16 bits
// - inner count 16 bits, never zero
// - outer count 16 bits, never zero
// - source outer stride between outer iterations
// - destination outer stride between outer iterations
// - source starts at 32-bit source address
// - destination starts at 32-bit destination address
// - channel state machine status always readable
// - status zero idle, nonzero when active
// - program descriptor only while channel idle
// - poll busy channel before new start
// - blocking copy waits started channel finish
package tcd_pkg;

    // ***************************************************
    // link word indices within a channel
    // ***************************************************
    localparam logic [2:0]  IDX_CFG    = 3'h0;
    localparam logic [2:0]  IDX_ISTR   = 3'h1;
    localparam logic [2:0]  IDX_CNT    = 3'h2;
    localparam logic [2:0]  IDX_OSTR   = 3'h3;
    localparam logic [2:0]  IDX_SRC    = 3'h4;
    localparam logic [2:0]  IDX_DST    = 3'h5;
    localparam logic [2:0]  IDX_START  = 3'h6;
    localparam logic [2:0]  IDX_STAT   = 3'h7;
    localparam int unsigned CFG_CHAIN  = 2;
    localparam logic [31:0] WORD_BYTES = 32'h4;
    localparam logic [15:0] CNT_LAST   = 16'h1;
    localparam logic        SEL_SECOND = 1'h1;

    // ***************************************************
    // controller wishbone map
    // ***************************************************
    localparam logic [31:0] WB_CMD   = 32'h0;
    localparam logic [31:0] WB_WDATA = 32'h4;
    localparam logic [31:0] WB_RDATA = 32'h8;
    localparam logic [31:0] WB_STAT  = 32'hc;
    localparam int unsigned CMD_CHAN = 3;
    localparam int unsigned CMD_WE   = 4;
    localparam int unsigned CMD_WAIT = 5;

    // ***************************************************
    // state machines
    // ***************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11,
        ST_FETCH = 2'b10
    } tcd_st_type;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_PRE  = 2'b01,
        H_ACC  = 2'b11,
        H_POST = 2'b10
    } tcd_hst_type;

    typedef struct packed {
        tcd_st_type  st;
        logic [15:0] cfg;
        logic [15:0] nxt;
        logic [15:0] isrc;
        logic [15:0] idst;
        logic [15:0] icnt;
        logic [15:0] ocnt;
        logic [15:0] osrc;
        logic [15:0] odst;
        logic [31:0] sa;
        logic [31:0] da;
        logic [31:0] cs;
        logic [31:0] cd;
        logic [15:0] ic;
        logic [15:0] oc;
        logic [31:0] data;
        logic [2:0]  fidx;
    } tcd_chan_type;

    typedef struct packed {
        tcd_chan_type [1:0] ch;
        logic               busy;
        logic               own;
        logic               ack;
        logic [31:0]        rdata;
        logic               mreq;
        logic               mwe;
        logic [31:0]        maddr;
        logic [31:0]        mwdata;
    } tcd_dev_type;

    localparam tcd_dev_type DEV_RST = '0;

endpackage

// file: include/tcd_if.sv
// link between the dma controller and the two-channel dma device
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface tcd_if;
    logic        req;
    logic        we;
    logic        chan;
    logic [2:0]  idx;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;

    modport dev_mp (
        input  req,
        input  we,
        input  chan,
        input  idx,
        input  wdata,
        output ack,
        output rdata
    );

    modport ctl_mp (
        output req,
        output we,
        output chan,
        output idx,
        output wdata,
        input  ack,
        input  rdata
    );
endinterface

// file: verilog/tcd_dev.sv
// two-channel descriptor dma device: link register port and memory master
// assumes memory holds its request until it pulses mem_ack_i for one cycle
//
// Local design decisions: the register offsets and the link register port.
`timescale 1ns/1ns
module tcd_dev (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // controller link
    tcd_if.dev_mp            lnk,
    // memory master
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic [31:0]      mem_addr_o,
    output logic [31:0]      mem_wdata_o,
    input  wire logic [31:0] mem_rdata_i,
    input  wire logic        mem_ack_i
);

    tcd_pkg::tcd_dev_type s_ff;
    tcd_pkg::tcd_dev_type nxt_s;

    // ***************************************************
    // helpers
    // ***************************************************
    function automatic logic [31:0] sx(input logic [15:0] v);
        sx = {{16{v[15]}}, v};
    endfunction

    function automatic tcd_pkg::tcd_chan_type put_word(
        input tcd_pkg::tcd_chan_type c,
        input logic [2:0]            idx,
        input logic [31:0]           w
    );
        put_word = c;
        case (idx)
            tcd_pkg::IDX_CFG: begin
                put_word.cfg = w[15:0];
                put_word.nxt = w[31:16];
            end
            tcd_pkg::IDX_ISTR: begin
                put_word.isrc = w[15:0];
                put_word.idst = w[31:16];
            end
            tcd_pkg::IDX_CNT: begin
                put_word.icnt = w[15:0];
                put_word.ocnt = w[31:16];
            end
            tcd_pkg::IDX_OSTR: begin
                put_word.osrc = w[15:0];
                put_word.odst = w[31:16];
            end
            tcd_pkg::IDX_SRC: put_word.sa = w;
            tcd_pkg::IDX_DST: put_word.da = w;
            default: ;
        endcase
    endfunction

    function automatic logic [31:0] get_word(
        input tcd_pkg::tcd_chan_type c,
        input logic [2:0]            idx
    );
        case (idx)
            tcd_pkg::IDX_CFG:  get_word = {c.nxt, c.cfg};
            tcd_pkg::IDX_ISTR: get_word = {c.idst, c.isrc};
            tcd_pkg::IDX_CNT:  get_word = {c.ocnt, c.icnt};
            tcd_pkg::IDX_OSTR: get_word = {c.odst, c.osrc};
            tcd_pkg::IDX_SRC:  get_word = c.sa;
            tcd_pkg::IDX_DST:  get_word = c.da;
            tcd_pkg::IDX_STAT: get_word = {30'h0, c.st};
            default:           get_word = 32'h0;
        endcase
    endfunction

    function automatic tcd_pkg::tcd_chan_type start(input tcd_pkg::tcd_chan_type c);
        start = c;
        start.cs = c.sa;
        start.cd = c.da;
        start.ic = c.icnt;
        start.oc = c.ocnt;
        start.st = tcd_pkg::ST_READ;
    endfunction

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        logic                  found;
        logic                  c;
        tcd_pkg::tcd_chan_type ch;
        found = 1'b0;
        c     = 1'b0;
        ch    = '0;
        nxt_s = s_ff;

        // link register port, one-cycle ack
        nxt_s.ack = 1'b0;
        if (lnk.req && !s_ff.ack) begin
            nxt_s.ack = 1'b1;
            ch = s_ff.ch[lnk.chan];
            nxt_s.rdata = get_word(ch, lnk.idx);
            if (lnk.we) begin
                if (lnk.idx == tcd_pkg::IDX_START) begin
                    if (ch.st == tcd_pkg::ST_IDLE) begin
                        nxt_s.ch[lnk.chan] = start(ch);
                    end
                end else begin
                    nxt_s.ch[lnk.chan] = put_word(ch, lnk.idx, lnk.wdata);
                end
            end
        end

        // memory engine: finish the access in flight
        if (s_ff.busy && mem_ack_i) begin
            nxt_s.mreq = 1'b0;
            nxt_s.busy = 1'b0;
            ch = nxt_s.ch[s_ff.own];
            case (ch.st)
                tcd_pkg::ST_READ: begin
                    ch.data = mem_rdata_i;
                    ch.st   = tcd_pkg::ST_WRITE;
                end
                tcd_pkg::ST_WRITE: begin
                    ch.st = tcd_pkg::ST_READ;
                    if (ch.ic != tcd_pkg::CNT_LAST) begin
                        ch.ic = ch.ic - 16'h1;
                        ch.cs = ch.cs + sx(ch.isrc);
                        ch.cd = ch.cd + sx(ch.idst);
                    end else if (ch.oc != tcd_pkg::CNT_LAST) begin
                        ch.oc = ch.oc - 16'h1;
                        ch.ic = ch.icnt;
                        ch.cs = ch.cs + sx(ch.osrc);
                        ch.cd = ch.cd + sx(ch.odst);
                    end else if (ch.cfg[tcd_pkg::CFG_CHAIN]) begin
                        // chain to next descriptor
                        // fetch base kept in data: the first fetched word replaces nxt
                        ch.st   = tcd_pkg::ST_FETCH;
                        ch.fidx = 3'h0;
                        ch.data = {16'h0, ch.nxt};
                    end else begin
                        ch.st = tcd_pkg::ST_IDLE;
                    end
                end
                tcd_pkg::ST_FETCH: begin
                    // descriptor words load in index order
                    ch = put_word(ch, ch.fidx, mem_rdata_i);
                    if (ch.fidx == tcd_pkg::IDX_DST) begin
                        ch = start(ch);
                    end else begin
                        ch.fidx = ch.fidx + 3'h1;
                    end
                end
                default: ;
            endcase
            nxt_s.ch[s_ff.own] = ch;
        end

        // memory engine: issue next access, channel 0 first
        if (!s_ff.busy && !s_ff.mreq) begin
            for (int i = 0; i < 2; i++) begin
                if (!found && s_ff.ch[i].st != tcd_pkg::ST_IDLE) begin
                    found = 1'b1;
                    c     = i[0];
                end
            end
            if (found) begin
                ch          = s_ff.ch[c];
                nxt_s.busy  = 1'b1;
                nxt_s.own   = c;
                nxt_s.mreq  = 1'b1;
                nxt_s.mwe   = (ch.st == tcd_pkg::ST_WRITE);
                nxt_s.mwdata = ch.data;
                case (ch.st)
                    tcd_pkg::ST_READ:  nxt_s.maddr = ch.cs;
                    tcd_pkg::ST_WRITE: nxt_s.maddr = ch.cd;
                    default: nxt_s.maddr = ch.data +
                                           {29'h0, ch.fidx} * tcd_pkg::WORD_BYTES;
                endcase
            end
        end
    end

    // ***************************************************
    // state register
    // ***************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= tcd_pkg::DEV_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign lnk.ack     = s_ff.ack;
    assign lnk.rdata   = s_ff.rdata;
    assign mem_req_o   = s_ff.mreq;
    assign mem_we_o    = s_ff.mwe;
    assign mem_addr_o  = s_ff.maddr;
    assign mem_wdata_o = s_ff.mwdata;

endmodule

// file: verilog/tcd_wbs.sv
// wishbone classic slave holding the controller's order registers
// assumes a single-cycle master that holds its request until ack
`timescale 1ns/1ns
module tcd_wbs (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // order to sequencer
    input  wire logic        busy_i,
    input  wire logic [31:0] rdata_i,
    output logic             go_o,
    output logic [5:0]       cmd_o,
    output logic [31:0]      wdata_o
);

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic        go;
        logic [5:0]  cmd;
        logic [31:0] wdata;
    } tcd_wbs_type;

    tcd_wbs_type s_ff;
    tcd_wbs_type nxt_s;

    // ***************************************************
    // decode
    // ***************************************************
    always_comb begin
        nxt_s     = s_ff;
        nxt_s.ack = 1'b0;
        nxt_s.go  = 1'b0;
        if (cyc_i && stb_i && !s_ff.ack) begin
            nxt_s.ack = 1'b1;
            nxt_s.dat = 32'h0;
            if (adr_i == tcd_pkg::WB_CMD) begin
                nxt_s.dat = {26'h0, s_ff.cmd};
                if (we_i && sel_i[0] && !busy_i) begin
                    nxt_s.cmd = dat_i[5:0];
                    nxt_s.go  = 1'b1;
                end
            end else if (adr_i == tcd_pkg::WB_WDATA) begin
                nxt_s.dat = s_ff.wdata;
                if (we_i) begin
                    for (int b = 0; b < 4; b++) begin
                        if (sel_i[b]) begin
                            nxt_s.wdata[b*8 +: 8] = dat_i[b*8 +: 8];
                        end
                    end
                end
            end else if (adr_i == tcd_pkg::WB_RDATA) begin
                nxt_s.dat = rdata_i;
            end else if (adr_i == tcd_pkg::WB_STAT) begin
                nxt_s.dat = {31'h0, busy_i | s_ff.go};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign dat_o   = s_ff.dat;
    assign ack_o   = s_ff.ack;
    assign go_o    = s_ff.go;
    assign cmd_o   = s_ff.cmd;
    assign wdata_o = s_ff.wdata;

endmodule

// file: verilog/tcd_ctl.sv
// dma controller end: takes orders over wishbone and drives the link
// assumes the device answers each link request with a one-cycle ack
`timescale 1ns/1ns
module tcd_ctl (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // device link
    tcd_if.ctl_mp            lnk
);

    typedef struct packed {
        tcd_pkg::tcd_hst_type st;
        logic                 req;
        logic                 we;
        logic                 chan;
        logic [2:0]           idx;
        logic [31:0]          rdata;
        logic [5:0]           cmd;
        logic [31:0]          wdata;
    } tcd_ctl_type;

    tcd_ctl_type s_ff;
    tcd_ctl_type nxt_s;
    logic        go;
    logic [5:0]  cmd;
    logic [31:0] wdata;

    tcd_wbs u_wbs (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .cyc_i   (cyc_i),
        .stb_i   (stb_i),
        .we_i    (we_i),
        .adr_i   (adr_i),
        .sel_i   (sel_i),
        .dat_i   (dat_i),
        .dat_o   (dat_o),
        .ack_o   (ack_o),
        .busy_i  (s_ff.st != tcd_pkg::H_IDLE),
        .rdata_i (s_ff.rdata),
        .go_o    (go),
        .cmd_o   (cmd),
        .wdata_o (wdata)
    );

    // ***************************************************
    // link sequencer
    // ***************************************************
    always_comb begin
        nxt_s = s_ff;
        if (s_ff.req && lnk.ack) begin
            nxt_s.req = 1'b0;
        end else if (!s_ff.req && s_ff.st != tcd_pkg::H_IDLE) begin
            // request again one idle cycle after each answer
            nxt_s.req = 1'b1;
        end
        case (s_ff.st)
            tcd_pkg::H_IDLE: begin
                if (go) begin
                    nxt_s.cmd   = cmd;
                    nxt_s.wdata = wdata;
                    nxt_s.chan  = cmd[tcd_pkg::CMD_CHAN];
                    nxt_s.req   = 1'b1;
                    if (cmd[tcd_pkg::CMD_WE]) begin
                        nxt_s.st  = tcd_pkg::H_PRE;
                        nxt_s.we  = 1'b0;
                        nxt_s.idx = tcd_pkg::IDX_STAT;
                    end else begin
                        nxt_s.st  = tcd_pkg::H_ACC;
                        nxt_s.we  = 1'b0;
                        nxt_s.idx = cmd[2:0];
                    end
                end
            end
            tcd_pkg::H_PRE: begin
                if (s_ff.req && lnk.ack) begin
                    if (lnk.rdata == 32'h0) begin
                        nxt_s.st  = tcd_pkg::H_ACC;
                        nxt_s.we  = 1'b1;
                        nxt_s.idx = s_ff.cmd[2:0];
                    end
                end
            end
            tcd_pkg::H_ACC: begin
                if (s_ff.req && lnk.ack) begin
                    nxt_s.rdata = lnk.rdata;
                    nxt_s.st    = tcd_pkg::H_IDLE;
                    if (s_ff.we && s_ff.cmd[tcd_pkg::CMD_WAIT]
                        && s_ff.idx == tcd_pkg::IDX_START) begin
                        nxt_s.st  = tcd_pkg::H_POST;
                        nxt_s.we  = 1'b0;
                        nxt_s.idx = tcd_pkg::IDX_STAT;
                    end
                end
            end
            default: begin
                if (s_ff.req && lnk.ack) begin
                    nxt_s.rdata = lnk.rdata;
                    if (lnk.rdata == 32'h0) begin
                        nxt_s.st = tcd_pkg::H_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign lnk.req   = s_ff.req;
    assign lnk.we    = s_ff.we;
    assign lnk.chan  = s_ff.chan;
    assign lnk.idx   = s_ff.idx;
    assign lnk.wdata = s_ff.wdata;

endmodule

// file: sim/tcd_link_checker.sv
// link checker: assertions on the controller-device link signals
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module tcd_link_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        req,
    input wire logic        we,
    input wire logic        chan,
    input wire logic [2:0]  idx,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ***************************************************
    // link handshake
    // ***************************************************
    // answer one cycle after take
    a_ack_follows_req: assert property ($rose(req) |=> ack)
        else $error("link ack not one cycle after request");
    a_ack_one_pulse: assert property (ack |=> !ack)
        else $error("link ack longer than one cycle");
    a_ack_has_cause: assert property (ack |-> $past(req))
        else $error("link ack without request");
    // request and qualifiers held to ack
    a_req_held: assert property (req && !ack |=> req && $stable({we, chan, idx, wdata}))
        else $error("link request changed before ack");
    a_req_released: assert property (ack |=> !req)
        else $error("link request not released after ack");
    a_rdata_holds: assert property (!ack && !$past(rst_i) |-> $stable(rdata))
        else $error("link read data changed without ack");
    a_start_is_write: assert property (req && idx == tcd_pkg::IDX_START |-> we)
        else $error("start index read");
    a_status_no_write: assert property (req && we |-> idx != tcd_pkg::IDX_STAT)
        else $error("status index written");
endmodule

// file: sim/tb.sv
// bench: wishbone orders into the controller, both ends joined, word memory on the device
// assumes the memory may answer slowly; every wait is bounded
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb;
    logic        clk_i, rst_i, cyc, stb, wbwe, wb_ack, mem_req, mem_we, mem_ack, slow;
    logic [31:0] adr, wdat, rdat, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] mem [0:1023];
    logic [1:0]  lat_cnt;
    int          err_total;
    int          n_checks;

    tcd_if lnk();
    tcd_ctl u_tcd_ctl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(wbwe),
        .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(wb_ack), .lnk(lnk));
    tcd_dev u_tcd_dev (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk), .mem_req_o(mem_req),
        .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
        .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));
    tcd_link_checker u_tcd_link_checker (.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req),
        .we(lnk.we), .chan(lnk.chan), .idx(lnk.idx), .wdata(lnk.wdata), .ack(lnk.ack),
        .rdata(lnk.rdata));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ***************************************************
    // memory: latency alternates fast and slow
    // ***************************************************
    always @(posedge clk_i) begin
        if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            slow <= ~slow;
            lat_cnt <= 2'h0;
        end else if (mem_req) begin
            lat_cnt <= lat_cnt + 2'h1;
            if (lat_cnt == (slow ? 2'h3 : 2'h0)) begin
                mem_ack <= 1'b1;
                if (mem_we) mem[mem_addr[11:2]] <= mem_wdata;
                else mem_rdata <= mem[mem_addr[11:2]];
            end
        end
    end

    function automatic logic [31:0] init_val(input int i);
        return 32'ha5a50000 | i;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ***************************************************
    // bus tasks
    // ***************************************************
    task automatic wb_cyc(input logic w, input logic [31:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        wbwe <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (wb_ack === 1'b1) break;
        end
        q = rdat;
        if (n == 50) begin
            err_total++;
            end_of_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic link_op(input logic c, input logic [2:0] i, input logic w, input logic wt,
                           input logic [31:0] d, output logic [31:0] q);
        logic [31:0] s;
        if (w) wb_cyc(1'b1, tcd_pkg::WB_WDATA, d, s);
        wb_cyc(1'b1, tcd_pkg::WB_CMD, {26'h0, wt, w, c, i}, s);
        for (int k = 0; k < 500; k++) begin
            wb_cyc(1'b0, tcd_pkg::WB_STAT, 32'h0, s);
            if (s[0] === 1'b0) break;
            if (k == 499) begin
                err_total++;
                end_of_test();
            end
        end
        wb_cyc(1'b0, tcd_pkg::WB_RDATA, 32'h0, q);
    endtask

    task automatic set_desc(input logic c, input logic [31:0] w [6]);
        logic [31:0] q;
        for (int k = 0; k < 6; k++) link_op(c, k[2:0], 1'b1, 1'b0, w[k], q);
    endtask

    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic t_reset();
        logic [31:0] q;
        for (int c = 0; c < 2; c++) begin
            link_op(c[0], tcd_pkg::IDX_STAT, 1'b0, 1'b0, 32'h0, q);
            `CHK("idle status", 32'h0, q)
        end
        wb_cyc(1'b0, 32'h10, 32'h0, q);
        `CHK("unmapped read", 32'h0, q)
    endtask

    task automatic t_copy();
        logic [31:0] q;
        int          s;
        int          d;
        set_desc(tcd_pkg::SEL_SECOND, '{32'h0, 32'h00040004, 32'h00020003, 32'h000c0008,
                                        32'h100, 32'h200});
        link_op(tcd_pkg::SEL_SECOND, tcd_pkg::IDX_CNT, 1'b0, 1'b0, 32'h0, q);
        `CHK("count word", 32'h00020003, q)
        link_op(tcd_pkg::SEL_SECOND, tcd_pkg::IDX_START, 1'b1, 1'b1, 32'h0, q);
        link_op(tcd_pkg::SEL_SECOND, tcd_pkg::IDX_STAT, 1'b0, 1'b0, 32'h0, q);
        `CHK("done status", 32'h0, q)
        for (int o = 0; o < 2; o++) begin
            for (int i = 0; i < 3; i++) begin
                s = 32'h100 + o * 16 + i * 4;
                d = 32'h200 + o * 20 + i * 4;
                `CHK("copied word", init_val(s >> 2), mem[d >> 2])
            end
        end
        `CHK("gap word", init_val(32'h83), mem[32'h83])
    endtask

    task automatic t_chain();
        logic [31:0] q;
        mem[16] = 32'h0;
        mem[17] = 32'h00040004;
        mem[18] = 32'h00010002;
        mem[19] = 32'h0;
        mem[20] = 32'h300;
        mem[21] = 32'h380;
        set_desc(1'b0, '{32'h00400004, 32'h00040004, 32'h00010001, 32'h0, 32'h180, 32'h280});
        link_op(1'b0, tcd_pkg::IDX_START, 1'b1, 1'b0, 32'h0, q);
        link_op(1'b0, tcd_pkg::IDX_STAT, 1'b0, 1'b0, 32'h0, q);
        `CHK("active status", 1'b1, q != 32'h0)
        link_op(tcd_pkg::SEL_SECOND, tcd_pkg::IDX_STAT, 1'b0, 1'b0, 32'h0, q);
        `CHK("other channel", 32'h0, q)
        for (int k = 0; k < 100; k++) begin
            link_op(1'b0, tcd_pkg::IDX_STAT, 1'b0, 1'b0, 32'h0, q);
            if (q === 32'h0) break;
        end
        `CHK("chain idle", 32'h0, q)
        `CHK("first word", init_val(32'h60), mem[32'ha0])
        `CHK("fetched 0", init_val(32'hc0), mem[32'he0])
        `CHK("fetched 1", init_val(32'hc1), mem[32'he1])
    endtask

    initial begin
        rst_i = 1'b1;
        {cyc, stb, wbwe, mem_ack, slow} = 5'h0;
        {adr, wdat, mem_rdata} = '0;
        lat_cnt = 2'h0;
        err_total = 0;
        n_checks = 0;
        for (int i = 0; i < 1024; i++) mem[i] = init_val(i);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_copy();
        t_chain();
        end_of_test();
    end
endmodule
